/* File: fsp_device.sv */
// Device end: link shift logic on the transfer clock, mode entry and buffering on clk
//
// Overview of operation
// - Serial mode: CE high, PROGRAM_MODE_SELECT_LOW low, mode pin high
// - Mode pin low at release gives normal operation
// - Twenty oscillator cycles during reset before release
// - Programming unit makes transfer clock; device only follows
// - Busy low when ready, high when reception starts
// - Data moves in fixed eight-bit units
// - Serial data output is always actively driven
// - Only user area may be rewritten, never boot
// - Damaged boot area disables serial programming mode
// - Link uses exactly clock, data in, out, busy
// - Internal processor handles reception and rewriting
// - Sample on rise, change on fall, LSB first
// - Unit waits for busy low before next transfer
module fsp_device
    import fsp_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int AW = ADDR_W
)(
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Link
    fsp_link_if.dev link,
    // Received units towards the processor
    output logic rxValid,
    output logic [UNIT_W-1:0] rxData,
    input wire logic rxReady,
    // Units to send
    input wire logic txValid,
    input wire logic [UNIT_W-1:0] txData,
    output logic txReady,
    // Rewrite permission
    input wire logic rwValid,
    input wire logic [AW-1:0] rwAddr,
    output logic rwGrant,
    output logic rwReject,
    // Status
    input wire logic bootIntact,
    input wire logic flashBusy,
    output logic serialMode
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);

    typedef struct packed {
        logic [UNIT_W-1:0] shift;
        logic [UNIT_W-1:0] unitOut;
        logic [CNT_W-1:0] cnt;
        logic active;
        logic tog;
    } fsp_rise_t;

    typedef struct packed {
        logic [UNIT_W-1:0] shift;
        logic [CNT_W-1:0] cnt;
        logic bitOut;
    } fsp_fall_t;

    typedef struct packed {
        fsp_dev_state_t mode;
        logic [STRAP_W-1:0] strapCnt;
        logic [STRAP_N-1:0] strapS1;
        logic [STRAP_N-1:0] strapS2;
        logic actS1;
        logic actS2;
        logic actS3;
        logic togS1;
        logic togS2;
        logic togS3;
        logic [DEPTH-1:0][UNIT_W-1:0] mem;
        logic [PTR_W-1:0] wrPtr;
        logic [PTR_W-1:0] rdPtr;
        logic [PTR_W:0] count;
        logic rxValid;
        logic [UNIT_W-1:0] rxData;
        logic [UNIT_W-1:0] txNext;
        logic txFree;
        logic [UNIT_W-1:0] txHold;
        logic busy;
        logic grant;
        logic reject;
        logic serial;
    } fsp_sys_t;

    fsp_rise_t rise_q;
    fsp_rise_t rise_d;
    fsp_fall_t fall_q;
    fsp_fall_t fall_d;
    fsp_sys_t s_q;
    fsp_sys_t s_d;
    logic push;
    logic pop;
    logic inUser;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive shifter on rising transfer clock edges
    always_comb
    begin
        rise_d = rise_q;
        rise_d.shift = {link.serialDataIn, rise_q.shift[UNIT_W-1:1]};
        if (rise_q.cnt == LAST_BIT)
        begin
            rise_d.cnt = '0;
            rise_d.active = 1'b0;
            rise_d.unitOut = rise_d.shift;
            rise_d.tog = ~rise_q.tog;
        end
        else
        begin
            rise_d.cnt = CNT_W'(rise_q.cnt + 1'b1);
            rise_d.active = 1'b1;
        end
    end

    // Clock only ever taken as an input here
    always_ff @(posedge link.transferClock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rise_q <= '0;
        end
        else
        begin
            rise_q <= rise_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit shifter on falling edges; first fall of a unit loads the held byte
    always_comb
    begin
        fall_d = fall_q;
        if (fall_q.cnt == '0)
        begin
            fall_d.shift = s_q.txHold;
            fall_d.bitOut = s_q.txHold[0];
        end
        else
        begin
            fall_d.bitOut = fall_q.shift[fall_q.cnt];
        end
        fall_d.cnt = CNT_W'(fall_q.cnt + 1'b1);
    end

    always_ff @(negedge link.transferClock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fall_q <= '{shift: TX_IDLE, cnt: '0, bitOut: TX_IDLE[0]};
        end
        else
        begin
            fall_q <= fall_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode entry, crossing, receive buffer, transmit holding, busy
    always_comb
    begin
        s_d = s_q;
        s_d.strapS1 = {link.chipEnableSelect, link.programModeSelectLow, link.processorModePin};
        s_d.strapS2 = s_q.strapS1;
        s_d.actS1 = rise_q.active;
        s_d.actS2 = s_q.actS1;
        s_d.actS3 = s_q.actS2;
        s_d.togS1 = rise_q.tog;
        s_d.togS2 = s_q.togS1;
        s_d.togS3 = s_q.togS2;
        push = (s_q.togS2 != s_q.togS3) && s_q.serial;
        pop = s_q.rxValid && rxReady;
        case (s_q.mode)
            DEV_STRAP:
            begin
                if (s_q.strapCnt == STRAP_DELAY)
                begin
                    // Boot area must hold its control program to enter serial mode
                    if ((s_q.strapS2 == STRAP_SERIAL) && bootIntact)
                    begin
                        s_d.mode = DEV_SERIAL;
                    end
                    else
                    begin
                        s_d.mode = DEV_NORMAL;
                    end
                end
                else
                begin
                    s_d.strapCnt = STRAP_W'(s_q.strapCnt + 1'b1);
                end
            end
            DEV_SERIAL:
            begin
                s_d.mode = DEV_SERIAL;
            end
            DEV_NORMAL:
            begin
                s_d.mode = DEV_NORMAL;
            end
            default:
            begin
                s_d.mode = DEV_STRAP;
            end
        endcase
        s_d.serial = (s_d.mode == DEV_SERIAL);
        if (pop)
        begin
            s_d.rdPtr = (s_q.rdPtr == PTR_LAST) ? '0 : PTR_W'(s_q.rdPtr + 1'b1);
        end
        if (push && ((s_q.count != CNT_FULL) || pop))
        begin
            s_d.mem[s_q.wrPtr] = rise_q.unitOut;
            s_d.wrPtr = (s_q.wrPtr == PTR_LAST) ? '0 : PTR_W'(s_q.wrPtr + 1'b1);
            if (!pop)
            begin
                s_d.count = (PTR_W + 1)'(s_q.count + 1'b1);
            end
        end
        else if (pop)
        begin
            s_d.count = (PTR_W + 1)'(s_q.count - 1'b1);
        end
        s_d.rxValid = (s_d.count != '0);
        s_d.rxData = s_d.mem[s_d.rdPtr];
        // Held byte changes only at the end of a unit, while busy is still high
        if (push)
        begin
            s_d.txHold = s_q.txFree ? TX_IDLE : s_q.txNext;
            s_d.txFree = 1'b1;
        end
        if (txValid && s_q.txFree)
        begin
            s_d.txNext = txData;
            s_d.txFree = 1'b0;
        end
        s_d.busy = !s_d.serial || s_q.actS2 || s_q.actS3 || push
            || (s_d.count == CNT_FULL) || flashBusy;
        inUser = (rwAddr < BOOT_BASE) || (rwAddr > BOOT_LAST);
        s_d.grant = rwValid && s_q.serial && inUser;
        s_d.reject = rwValid && !(s_q.serial && inUser);
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
            s_q.mode <= DEV_STRAP;
            s_q.txFree <= 1'b1;
            s_q.txHold <= TX_IDLE;
            s_q.busy <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs; data out is push-pull with no enable
    assign link.serialDataOut = fall_q.bitOut;
    assign link.readyBusyOut = s_q.busy;
    assign rxValid = s_q.rxValid;
    assign rxData = s_q.rxData;
    assign txReady = s_q.txFree;
    assign rwGrant = s_q.grant;
    assign rwReject = s_q.reject;
    assign serialMode = s_q.serial;
endmodule : fsp_device

/* File: fsp_pkg.sv */
// Shared constants and types for the serial flash programming port
package fsp_pkg;
    localparam int UNIT_W = 8;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
    localparam logic [UNIT_W-1:0] TX_IDLE = 8'hff;
    localparam int FIFO_DEPTH = 2;
    localparam int ADDR_W = 24;
    localparam logic [ADDR_W-1:0] BOOT_BASE = 24'h0fc000;
    localparam logic [ADDR_W-1:0] BOOT_LAST = 24'h0fffff;
    // Strap order: chip enable select, program mode select low, processor mode
    localparam int STRAP_N = 3;
    localparam logic [STRAP_N-1:0] STRAP_SERIAL = 3'h5;
    localparam int STRAP_W = 2;
    localparam logic [STRAP_W-1:0] STRAP_DELAY = 2'h2;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_HOLD_CYCLES = 20;
    localparam int LINK_HALF_DIV = 4;
    localparam int BUSY_GUARD_CYCLES = 8;
    localparam int TIMER_W = 16;
    localparam int EDGE_W = 5;
    localparam logic [EDGE_W-1:0] EDGES_PER_UNIT = 5'h10;

    typedef enum logic [2:0] {
        DEV_STRAP = 3'h1,
        DEV_SERIAL = 3'h2,
        DEV_NORMAL = 3'h4
    } fsp_dev_state_t;

    typedef enum logic [3:0] {
        HST_HOLD = 4'h1,
        HST_IDLE = 4'h2,
        HST_SHIFT = 4'h4,
        HST_GUARD = 4'h8
    } fsp_host_state_t;
endpackage : fsp_pkg

/* File: fsp_link_if.sv */
// Four-wire programming link plus mode straps and target reset
interface fsp_link_if;
    logic transferClock;
    logic serialDataIn;
    logic serialDataOut;
    logic readyBusyOut;
    logic chipEnableSelect;
    logic programModeSelectLow;
    logic processorModePin;
    logic targetReset;

    modport dev (
        input transferClock,
        input serialDataIn,
        output serialDataOut,
        output readyBusyOut,
        input chipEnableSelect,
        input programModeSelectLow,
        input processorModePin
    );

    modport host (
        output transferClock,
        output serialDataIn,
        input serialDataOut,
        input readyBusyOut,
        output chipEnableSelect,
        output programModeSelectLow,
        output processorModePin,
        output targetReset
    );
endinterface : fsp_link_if

/* File: fsp_host.sv */
// Programming unit end: target reset and straps, clock divider, unit shifter
module fsp_host
    import fsp_pkg::*;
#(
    parameter int HALF = LINK_HALF_DIV,
    parameter int HOLD = RESET_HOLD_CYCLES,
    parameter int GUARD = BUSY_GUARD_CYCLES
)(
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Link
    fsp_link_if.host link,
    // User side
    input wire logic wantSerial,
    input wire logic txValid,
    input wire logic [UNIT_W-1:0] txData,
    output logic txReady,
    output logic rxValid,
    output logic [UNIT_W-1:0] rxData
);
    typedef struct packed {
        fsp_host_state_t st;
        logic [TIMER_W-1:0] timer;
        logic [TIMER_W-1:0] div;
        logic [EDGE_W-1:0] edges;
        logic [UNIT_W-1:0] txShift;
        logic [UNIT_W-1:0] rxShift;
        logic sclk;
        logic sdi;
        logic rstOut;
        logic procMode;
        logic busyS1;
        logic busyS2;
        logic sdoS1;
        logic sdoS2;
        logic txReady;
        logic rxValid;
        logic [UNIT_W-1:0] rxData;
    } fsp_host_reg_t;

    fsp_host_reg_t h_q;
    fsp_host_reg_t h_d;

    always_comb
    begin
        h_d = h_q;
        h_d.busyS1 = link.readyBusyOut;
        h_d.busyS2 = h_q.busyS1;
        h_d.sdoS1 = link.serialDataOut;
        h_d.sdoS2 = h_q.sdoS1;
        h_d.rxValid = 1'b0;
        case (h_q.st)
            HST_HOLD:
            begin
                h_d.procMode = wantSerial;
                if (h_q.timer == TIMER_W'(HOLD - 1))
                begin
                    h_d.rstOut = 1'b0;
                    h_d.timer = '0;
                    h_d.st = HST_GUARD;
                end
                else
                begin
                    h_d.timer = TIMER_W'(h_q.timer + 1'b1);
                end
            end
            HST_IDLE:
            begin
                if (h_q.txReady && txValid)
                begin
                    h_d.txShift = txData;
                    h_d.edges = '0;
                    h_d.div = '0;
                    h_d.st = HST_SHIFT;
                end
            end
            HST_SHIFT:
            begin
                if (h_q.div == TIMER_W'(HALF - 1))
                begin
                    h_d.div = '0;
                    h_d.edges = EDGE_W'(h_q.edges + 1'b1);
                    if (!h_q.edges[0])
                    begin
                        if (h_q.edges != '0)
                        begin
                            h_d.rxShift = {h_q.sdoS2, h_q.rxShift[UNIT_W-1:1]};
                        end
                        if (h_q.edges == EDGES_PER_UNIT)
                        begin
                            h_d.rxValid = 1'b1;
                            h_d.rxData = h_d.rxShift;
                            h_d.timer = '0;
                            h_d.st = HST_GUARD;
                        end
                        else
                        begin
                            h_d.sclk = 1'b0;
                            h_d.sdi = h_q.txShift[0];
                            h_d.txShift = {1'b1, h_q.txShift[UNIT_W-1:1]};
                        end
                    end
                    else
                    begin
                        h_d.sclk = 1'b1;
                    end
                end
                else
                begin
                    h_d.div = TIMER_W'(h_q.div + 1'b1);
                end
            end
            HST_GUARD:
            begin
                // Lets the device raise busy before it is looked at again
                if (h_q.timer == TIMER_W'(GUARD - 1))
                begin
                    h_d.st = HST_IDLE;
                end
                else
                begin
                    h_d.timer = TIMER_W'(h_q.timer + 1'b1);
                end
            end
            default:
            begin
                h_d.st = HST_HOLD;
            end
        endcase
        h_d.txReady = (h_d.st == HST_IDLE) && h_q.procMode && !h_q.busyS2
            && !(h_q.st == HST_IDLE && h_q.txReady && txValid);
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            h_q <= '0;
            h_q.st <= HST_HOLD;
            h_q.sclk <= 1'b1;
            h_q.sdi <= 1'b1;
            h_q.rstOut <= 1'b1;
            h_q.busyS1 <= 1'b1;
            h_q.busyS2 <= 1'b1;
        end
        else
        begin
            h_q <= h_d;
        end
    end

    assign link.transferClock = h_q.sclk;
    assign link.serialDataIn = h_q.sdi;
    assign link.targetReset = h_q.rstOut;
    assign link.chipEnableSelect = 1'b1;
    assign link.programModeSelectLow = 1'b0;
    assign link.processorModePin = h_q.procMode;
    assign txReady = h_q.txReady;
    assign rxValid = h_q.rxValid;
    assign rxData = h_q.rxData;
endmodule : fsp_host

/* File: fsp_link_sva.sv */
// Concurrent checks on the programming link between the two ends
module fsp_link_sva (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Link
    input wire logic transferClock,
    input wire logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic readyBusyOut,
    input wire logic chipEnableSelect,
    input wire logic programModeSelectLow,
    input wire logic processorModePin,
    input wire logic targetReset
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] hiCnt_q;
    logic [3:0] falls_q;
    logic [4:0] holdCnt_q;
    logic [4:0] lowAgo_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////
    // Idle, unit bit and busy history counters
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hiCnt_q <= 5'h1f;
            falls_q <= 4'h0;
            holdCnt_q <= 5'h0;
            lowAgo_q <= 5'h0;
        end
        else
        begin
            hiCnt_q <= !transferClock ? 5'h0 : (hiCnt_q == 5'h1f) ? hiCnt_q : hiCnt_q + 5'h1;
            if (!transferClock && hiCnt_q != 5'h0)
                falls_q <= (hiCnt_q > 5'h6) ? 4'h1 : falls_q + 4'h1;
            else if (hiCnt_q > 5'h6)
                falls_q <= 4'h0;
            holdCnt_q <= !targetReset ? 5'h0 : (holdCnt_q == 5'h1f) ? holdCnt_q : holdCnt_q + 5'h1;
            lowAgo_q <= !readyBusyOut ? 5'h0 : (lowAgo_q == 5'h1f) ? lowAgo_q : lowAgo_q + 5'h1;
        end
    end

    ////////////////////////////////////////////////////////////
    sequence s_unitStart;
        (hiCnt_q > 5'h6) ##1 !transferClock;
    endsequence
    sequence s_normalRelease;
        $fell(targetReset) && !processorModePin;
    endsequence

    property p_strap;
        chipEnableSelect && !programModeSelectLow;
    endproperty
    a_strap: assert property (p_strap) else $error("mode straps wrong");
    property p_hold;
        $fell(targetReset) |-> holdCnt_q >= 5'd20;
    endproperty
    a_hold: assert property (p_hold) else $error("target reset too short");
    property p_busyInReset;
        targetReset |-> readyBusyOut;
    endproperty
    a_busyInReset: assert property (p_busyInReset) else $error("ready in reset");
    property p_busyOnRise;
        $rose(transferClock) |-> ##[0:4] readyBusyOut;
    endproperty
    a_busyOnRise: assert property (p_busyOnRise) else $error("no busy on reception");
    property p_startAfterLow;
        s_unitStart |-> lowAgo_q < 5'h10;
    endproperty
    a_startAfterLow: assert property (p_startAfterLow) else $error("unit began while busy");
    property p_unitBits;
        hiCnt_q == 5'h6 |-> falls_q == 4'h0 || falls_q == 4'h8;
    endproperty
    a_unitBits: assert property (p_unitBits) else $error("unit not eight bits");
    property p_sdiStable;
        transferClock && $past(transferClock) |-> $stable(serialDataIn);
    endproperty
    a_sdiStable: assert property (p_sdiStable) else $error("data in moved on high");
    property p_sdoStable;
        disable iff (sys_rst || targetReset)
        transferClock && $past(transferClock) |-> $stable(serialDataOut);
    endproperty
    a_sdoStable: assert property (p_sdoStable) else $error("data out moved on high");
    property p_normalBusy;
        s_normalRelease |-> readyBusyOut [*8];
    endproperty
    a_normalBusy: assert property (p_normalBusy) else $error("ready in normal mode");
    property p_idleNotSerial;
        !processorModePin |-> transferClock && serialDataIn;
    endproperty
    a_idleNotSerial: assert property (p_idleNotSerial) else $error("link active");
endmodule : fsp_link_sva

/* File: flash_serial_program_port_tb.sv */
// Bench joining the programming unit end to the device end
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module flash_serial_program_port_tb
    import fsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wantSerial = 1'b1;
    logic bootIntact = 1'b1;
    logic flashBusy = 1'b0;
    logic hTxValid = 1'b0;
    logic dTxValid = 1'b0;
    logic dRxReady = 1'b1;
    logic rwValid = 1'b0;
    logic [UNIT_W-1:0] hTxData = 8'h00;
    logic [UNIT_W-1:0] dTxData = 8'h00;
    logic [ADDR_W-1:0] rwAddr = 24'h000000;
    logic hTxReady, hRxValid, dRxValid, dTxReady, rwGrant, rwReject, serialMode;
    logic [UNIT_W-1:0] hRxData, dRxData, devHold, expD, expH;
    logic [UNIT_W-1:0] expDev[$];
    logic [UNIT_W-1:0] expHost[$];
    logic [31:0] seed = 32'h976e;
    logic [ADDR_W-1:0] corner [6] = '{24'h0fbfff, 24'h0fc000, 24'h0fffff, 24'h100000,
                                      24'h000000, 24'hffffff};
    int err_total = 0;
    int num_checks = 0;

    fsp_link_if link();
    fsp_host fsp_host_i (.clk(clk), .sys_rst(sys_rst), .link(link.host),
        .wantSerial(wantSerial), .txValid(hTxValid), .txData(hTxData),
        .txReady(hTxReady), .rxValid(hRxValid), .rxData(hRxData));
    fsp_device fsp_device_i (.clk(clk), .sys_rst(link.targetReset), .link(link.dev),
        .rxValid(dRxValid), .rxData(dRxData), .rxReady(dRxReady), .txValid(dTxValid),
        .txData(dTxData), .txReady(dTxReady), .rwValid(rwValid), .rwAddr(rwAddr),
        .rwGrant(rwGrant), .rwReject(rwReject), .bootIntact(bootIntact),
        .flashBusy(flashBusy), .serialMode(serialMode));
    fsp_link_sva fsp_link_sva_i (.clk(clk), .sys_rst(sys_rst),
        .transferClock(link.transferClock), .serialDataIn(link.serialDataIn),
        .serialDataOut(link.serialDataOut), .readyBusyOut(link.readyBusyOut),
        .chipEnableSelect(link.chipEnableSelect), .targetReset(link.targetReset),
        .programModeSelectLow(link.programModeSelectLow),
        .processorModePin(link.processorModePin));

    initial
    begin
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [1:0] expRw(input logic [ADDR_W-1:0] a, input logic m);
        logic g;
        g = m && (a < BOOT_BASE || a > BOOT_LAST);
        return {g, ~g};
    endfunction : expRw

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic stop_test;
        $display("Errors %0d, checks %0d", err_total, num_checks);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    // Kind 0 waits for the unit to accept, kind 1 for all units to arrive
    task automatic waitCond(input int kind);
        for (int i = 0; i < 3000; i++)
        begin
            if (kind == 0 ? hTxReady === 1'b1 : expDev.size() + expHost.size() == 0)
                return;
            cyc(1);
        end
        err_total++;
        $display("[FAIL] %0t wait ran out", $time);
        stop_test();
    endtask : waitCond

    task automatic resetAll(input logic ws, input logic boot);
        sys_rst = 1'b1;
        wantSerial = ws;
        bootIntact = boot;
        devHold = TX_IDLE;
        cyc(6);
        sys_rst = 1'b0;
    endtask : resetAll

    task automatic sendUnit(input logic [7:0] hb, input logic [7:0] db, input logic ld);
        waitCond(0);
        `CHECK(dTxReady, 1'b1)
        expDev.push_back(hb);
        expHost.push_back(devHold);
        devHold = ld ? db : TX_IDLE;
        dTxValid = ld;
        dTxData = db;
        hTxValid = 1'b1;
        hTxData = hb;
        cyc(1);
        `CHECK(dTxReady, !ld)
        dTxValid = 1'b0;
        hTxValid = 1'b0;
    endtask : sendUnit

    task automatic rwCheck(input logic [ADDR_W-1:0] a, input logic m);
        logic [1:0] got;
        rwValid = 1'b1;
        rwAddr = a;
        cyc(1);
        rwValid = 1'b0;
        got = {rwGrant, rwReject};
        `CHECK(got, expRw(a, m))
        cyc(1);
        // Answer is a single-cycle pulse
        got = {rwGrant, rwReject};
        `CHECK(got, 2'h0)
    endtask : rwCheck

    ////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        if (dRxValid === 1'b1 && dRxReady === 1'b1)
        begin
            expD = expDev.size() ? expDev.pop_front() : 8'hxx;
            `CHECK(dRxData, expD)
        end
        if (hRxValid === 1'b1)
        begin
            expH = expHost.size() ? expHost.pop_front() : 8'hxx;
            `CHECK(hRxData, expH)
        end
    end

    initial
    begin
        resetAll(1'b1, 1'b1);
        waitCond(0);
        `CHECK(serialMode, 1'b1)
        `CHECK(link.readyBusyOut, 1'b0)
        sendUnit(8'h01, 8'h80, 1'b1);
        sendUnit(8'h80, 8'h00, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            sendUnit(seed[7:0], seed[15:8], seed[16]);
        end
        waitCond(1);
        dRxReady = 1'b0;
        sendUnit(8'h5a, 8'ha5, 1'b1);
        sendUnit(8'hc3, 8'h3c, 1'b1);
        cyc(150);
        `CHECK(hTxReady, 1'b0)
        `CHECK(link.readyBusyOut, 1'b1)
        dRxReady = 1'b1;
        waitCond(1);
        flashBusy = 1'b1;
        cyc(8);
        `CHECK(link.readyBusyOut, 1'b1)
        `CHECK(hTxReady, 1'b0)
        flashBusy = 1'b0;
        sendUnit(8'hff, 8'h00, 1'b0);
        waitCond(1);
        for (int i = 0; i < 6; i++)
            rwCheck(corner[i], 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            rwCheck(seed[ADDR_W-1:0], 1'b1);
        end
        resetAll(1'b0, 1'b1);
        cyc(60);
        `CHECK(serialMode, 1'b0)
        `CHECK(link.readyBusyOut, 1'b1)
        `CHECK(hTxReady, 1'b0)
        rwCheck(24'h001000, 1'b0);
        resetAll(1'b1, 1'b0);
        cyc(60);
        `CHECK(serialMode, 1'b0)
        `CHECK(link.readyBusyOut, 1'b1)
        stop_test();
    end
endmodule : flash_serial_program_port_tb
